//--- mqflag_pkg.sv
// Shared constants, types and decoders for the multi-queue flag expansion link
//------------------------------------------------------------------------------
// Functional notes
// - Polled mode loads devices' status in turn
// - Sync high during own status cycle
// - Chain out pulses; next device loads next
// - Board loops chain outputs into a ring
// - Single device: chain in low or looped
// - Direct chain: first chain input held low
// - Strobe idle until serial enable low
// - Six-bit write, seven-bit read queue address
// - Top three address bits must match code
// - Device code latched at master reset
// - Single device: code zero, top bits low
// - Primary select sampled; secondaries start released
// - Single device holds primary select high
// - Master reset is low pulse, then program
// - Primary: output enable gates data asynchronously
// - Secondary data released until read-selected
// - Valid flag delayed two read cycles
// - Read to empty drives valid flag high
// - Valid flag can release its line
// - Width selects give x9/x18/x36, one x36
// - Flag mode sampled: high polled, low direct
// - Direct mode: strobe selects addressed device
//------------------------------------------------------------------------------
package mqflag_pkg;

	localparam int WR_ADDR_W  = 6;
	localparam int RD_ADDR_W  = 7;
	localparam int CODE_W     = 3;
	localparam int NUM_QUEUES = 8;
	localparam int QIDX_W     = 3;
	localparam int DATA_W     = 36;
	localparam int AXI_ADDR_W = 4;

	localparam logic [1:0] WIDTH_X9  = 2'h0;
	localparam logic [1:0] WIDTH_X18 = 2'h1;
	localparam logic [1:0] WIDTH_X36 = 2'h2;

	// Controller register map (byte offsets)
	localparam logic [AXI_ADDR_W-1:0] CTRL_OFF = 4'h0;
	localparam logic [AXI_ADDR_W-1:0] WSEL_OFF = 4'h4;
	localparam logic [AXI_ADDR_W-1:0] RSEL_OFF = 4'h8;
	localparam logic [AXI_ADDR_W-1:0] STAT_OFF = 4'hc;

	// Control register fields
	localparam int CTRL_RESET_BIT = 0;
	localparam int CTRL_CODE_LSB  = 1;
	localparam int CTRL_PRIM_BIT  = 4;
	localparam int CTRL_FMODE_BIT = 5;
	localparam int CTRL_IW_BIT    = 6;
	localparam int CTRL_OW_BIT    = 7;
	localparam int CTRL_BM_BIT    = 8;
	localparam int CTRL_W         = 9;
	localparam logic [CTRL_W-1:0] CTRL_RESET_VAL = 9'h011;

	// Select register fields
	localparam int SEL_FLAG_BIT = 8;

	// Status register fields
	localparam int STAT_SYNC_BIT  = 8;
	localparam int STAT_OV_BIT    = 9;
	localparam int STAT_SERIAL_ENABLE_OUT_BIT  = 10;
	localparam int STAT_CHAIN_BIT = 11;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		WR_IDLE,
		WR_RESP
	} wr_state_t;

	// Port widths {input, output}; at least one port is always x36
	function automatic logic [3:0] width_decode(input logic iw, input logic ow, input logic bm);
		logic [3:0] w;
		w = {WIDTH_X36, WIDTH_X36};
		if (bm && iw)
			w = {(ow ? WIDTH_X18 : WIDTH_X9), WIDTH_X36};
		else if (bm)
			w = {WIDTH_X36, (ow ? WIDTH_X18 : WIDTH_X9)};
		return w;
	endfunction

endpackage

//--- mq_link_if.sv
// Pin-level link between the controller and the multi-queue device
`timescale 1ns/1ps
interface mq_link_if;

	// Configuration and reset
	logic                                   master_reset_n;
	logic [mqflag_pkg::CODE_W-1:0]          chip_select_code;
	logic                                   primary_device_select;
	logic                                   flag_mode_select;
	logic                                   input_width_sel;
	logic                                   output_width_sel;
	logic                                   bus_match_select;
	logic                                   serial_enable_out;
	// Queue selection
	logic [mqflag_pkg::WR_ADDR_W-1:0]       write_queue_address;
	logic                                   write_queue_select;
	logic [mqflag_pkg::RD_ADDR_W-1:0]       read_queue_address;
	logic                                   read_queue_select;
	logic                                   output_enable_n;
	// Almost-full status bus and chain
	logic                                   almost_full_bus_strobe;
	logic [mqflag_pkg::NUM_QUEUES-1:0]      almost_full_status_bus;
	logic                                   status_bus_oe_n;
	logic                                   almost_full_bus_sync;
	logic                                   almost_full_chain_in;
	logic                                   almost_full_chain_out;
	// Read data and valid flag
	logic [mqflag_pkg::DATA_W-1:0]          read_data;
	logic                                   read_data_oe_n;
	logic                                   output_valid_flag_n;
	logic                                   output_valid_oe_n;
	// Resolved line levels, released lines pulled high
	logic [mqflag_pkg::NUM_QUEUES-1:0]      status_bus_line;
	logic [mqflag_pkg::DATA_W-1:0]          read_data_line;
	logic                                   output_valid_line_n;

	assign status_bus_line     = status_bus_oe_n ? '1 : almost_full_status_bus;
	assign read_data_line      = read_data_oe_n ? '1 : read_data;
	assign output_valid_line_n = output_valid_oe_n ? 1'b1 : output_valid_flag_n;

	modport device_end (
		input  master_reset_n, chip_select_code, primary_device_select, flag_mode_select,
		input  input_width_sel, output_width_sel, bus_match_select,
		input  write_queue_address, write_queue_select, read_queue_address,
		input  read_queue_select, output_enable_n, almost_full_bus_strobe,
		input  almost_full_chain_in,
		output serial_enable_out, almost_full_status_bus, status_bus_oe_n,
		output almost_full_bus_sync, almost_full_chain_out,
		output read_data, read_data_oe_n, output_valid_flag_n, output_valid_oe_n
	);

	modport host_end (
		output master_reset_n, chip_select_code, primary_device_select, flag_mode_select,
		output input_width_sel, output_width_sel, bus_match_select,
		output write_queue_address, write_queue_select, read_queue_address,
		output read_queue_select, output_enable_n, almost_full_bus_strobe,
		output almost_full_chain_in,
		input  serial_enable_out, almost_full_bus_sync, almost_full_chain_out,
		input  status_bus_line, read_data_line, output_valid_line_n
	);

endinterface // mq_link_if

//--- mq_device_end.sv
// Device end: flag bus expansion, queue address decode and output control
`timescale 1ns/1ps
module mq_device_end #(
	parameter int NUM_QUEUES = mqflag_pkg::NUM_QUEUES,
	parameter int DATA_W     = mqflag_pkg::DATA_W
) (
	// Clock and reset
	input  wire logic                              core_clk,
	input  wire logic                              resetn,
	// Link pins
	mq_link_if.device_end                          link,
	// Queue core status
	input  wire logic [NUM_QUEUES-1:0]             queue_almost_full,
	input  wire logic [NUM_QUEUES-1:0]             queue_empty,
	input  wire logic [DATA_W-1:0]                 queue_read_word,
	input  wire logic                              programming_done,
	// Decoded selections to the queue core
	output logic                                   write_queue_hit,
	output logic [mqflag_pkg::QIDX_W-1:0]          write_queue_index,
	output logic                                   read_queue_owned,
	output logic [mqflag_pkg::QIDX_W-1:0]          read_queue_index,
	// Captured configuration
	output logic [1:0]                             input_width,
	output logic [1:0]                             output_width,
	output logic                                   primary_mode,
	output logic                                   polled_mode
);

	//--------------------------------------------------------------------------
	// Configuration capture
	//--------------------------------------------------------------------------
	logic [mqflag_pkg::CODE_W-1:0] code_q;
	logic                          primary_q;
	logic                          polled_q;
	logic [3:0]                    width_q;
	logic                          start_q;
	logic                          mrs_active;

	assign mrs_active = !link.master_reset_n;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			code_q    <= '0;
			primary_q <= 1'b0;
			polled_q  <= 1'b0;
			width_q   <= {mqflag_pkg::WIDTH_X36, mqflag_pkg::WIDTH_X36};
		end
		else if (mrs_active)
		begin
			code_q    <= link.chip_select_code;
			primary_q <= link.primary_device_select;
			polled_q  <= link.flag_mode_select;
			width_q   <= mqflag_pkg::width_decode(link.input_width_sel,
				link.output_width_sel, link.bus_match_select);
		end
	end

	// Master reset delayed one cycle; still high in the first cycle after release
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			start_q <= 1'b0;
		else
			start_q <= mrs_active;
	end

	assign input_width  = width_q[3:2];
	assign output_width = width_q[1:0];
	assign primary_mode = primary_q;
	assign polled_mode  = polled_q;

	//--------------------------------------------------------------------------
	// Queue address decode
	//--------------------------------------------------------------------------
	logic wr_match;
	logic rd_match;
	logic wr_hit_q;
	logic rd_owner_q;
	logic [mqflag_pkg::QIDX_W-1:0] wr_idx_q;
	logic [mqflag_pkg::QIDX_W-1:0] rd_idx_q;

	// Device field is the top three bits of each address
	assign wr_match = link.write_queue_address[mqflag_pkg::WR_ADDR_W-1 -: mqflag_pkg::CODE_W]
		== code_q;
	assign rd_match = link.read_queue_address[mqflag_pkg::RD_ADDR_W-1 -: mqflag_pkg::CODE_W]
		== code_q;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_hit_q <= 1'b0;
			wr_idx_q <= '0;
		end
		else if (mrs_active)
			wr_hit_q <= 1'b0;
		else
		begin
			wr_hit_q <= link.write_queue_select && wr_match;
			if (link.write_queue_select && wr_match)
				wr_idx_q <= link.write_queue_address[mqflag_pkg::QIDX_W-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rd_owner_q <= 1'b0;
			rd_idx_q   <= '0;
		end
		else if (mrs_active)
		begin
			rd_owner_q <= link.primary_device_select;
			rd_idx_q   <= '0;
		end
		else if (link.read_queue_select)
		begin
			rd_owner_q <= rd_match;
			if (rd_match)
				rd_idx_q <= link.read_queue_address[mqflag_pkg::QIDX_W-1:0];
		end
	end

	assign write_queue_hit   = wr_hit_q;
	assign write_queue_index = wr_idx_q;
	assign read_queue_owned  = rd_owner_q;
	assign read_queue_index  = rd_idx_q;

	//--------------------------------------------------------------------------
	// Almost-full status bus
	//--------------------------------------------------------------------------
	logic                  poll_load;
	logic                  direct_take;
	logic                  af_owner_q;
	logic [NUM_QUEUES-1:0] af_bus_q;
	logic                  af_oe_n_q;
	logic                  af_sync_q;
	logic                  chain_out_q;

	// Token from the previous device, or the primary starting the ring
	assign poll_load   = polled_q && (link.almost_full_chain_in
		|| (start_q && primary_q));
	assign direct_take = !polled_q && link.almost_full_bus_strobe;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			af_owner_q <= 1'b0;
		else if (mrs_active)
			af_owner_q <= link.primary_device_select;
		else if (direct_take)
			af_owner_q <= wr_match;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			af_bus_q    <= '1;
			af_oe_n_q   <= 1'b1;
			af_sync_q   <= 1'b0;
			chain_out_q <= 1'b0;
		end
		else if (mrs_active)
		begin
			af_bus_q    <= '1;
			af_oe_n_q   <= 1'b1;
			af_sync_q   <= 1'b0;
			chain_out_q <= 1'b0;
		end
		else
		begin
			af_bus_q    <= ~queue_almost_full;
			af_oe_n_q   <= polled_q ? !poll_load : !af_owner_q;
			af_sync_q   <= poll_load;
			chain_out_q <= poll_load;
		end
	end

	assign link.almost_full_status_bus = af_bus_q;
	assign link.status_bus_oe_n        = af_oe_n_q;
	assign link.almost_full_bus_sync   = af_sync_q;
	assign link.almost_full_chain_out  = chain_out_q;

	//--------------------------------------------------------------------------
	// Read data and output valid flag
	//--------------------------------------------------------------------------
	logic [DATA_W-1:0] rdata_q;
	logic              ov_stage_q;
	logic              ov_n_q;
	logic              ov_oe_n_q;
	logic              serial_enable_out_q;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rdata_q    <= '0;
			ov_stage_q <= 1'b1;
			ov_n_q     <= 1'b1;
			ov_oe_n_q  <= 1'b1;
			serial_enable_out_q     <= 1'b1;
		end
		else
		begin
			rdata_q    <= queue_read_word;
			ov_stage_q <= queue_empty[rd_idx_q] || mrs_active;
			ov_n_q     <= ov_stage_q;
			ov_oe_n_q  <= !rd_owner_q;
			serial_enable_out_q     <= mrs_active || !programming_done;
		end
	end

	// Output enable acts without the clock once the port is owned
	assign link.read_data_oe_n      = link.output_enable_n || !rd_owner_q;
	assign link.read_data           = rdata_q;
	assign link.output_valid_flag_n = ov_n_q;
	assign link.output_valid_oe_n   = ov_oe_n_q;
	assign link.serial_enable_out   = serial_enable_out_q;

endmodule // mq_device_end

//--- mq_host_end.sv
// Controller end: AXI4-Lite registers driving the device link pins
`timescale 1ns/1ps
module mq_host_end (
	// Clock and reset
	input  wire logic                                  core_clk,
	input  wire logic                                  resetn,
	// AXI4-Lite write channels
	input  wire logic [mqflag_pkg::AXI_ADDR_W-1:0]     s_axi_awaddr,
	input  wire logic                                  s_axi_awvalid,
	output logic                                       s_axi_awready,
	input  wire logic [31:0]                           s_axi_wdata,
	input  wire logic [3:0]                            s_axi_wstrb,
	input  wire logic                                  s_axi_wvalid,
	output logic                                       s_axi_wready,
	output logic [1:0]                                 s_axi_bresp,
	output logic                                       s_axi_bvalid,
	input  wire logic                                  s_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [mqflag_pkg::AXI_ADDR_W-1:0]     s_axi_araddr,
	input  wire logic                                  s_axi_arvalid,
	output logic                                       s_axi_arready,
	output logic [31:0]                                s_axi_rdata,
	output logic [1:0]                                 s_axi_rresp,
	output logic                                       s_axi_rvalid,
	input  wire logic                                  s_axi_rready,
	// Link pins
	mq_link_if.host_end                                link
);

	//--------------------------------------------------------------------------
	// Write path
	//--------------------------------------------------------------------------
	logic                                aw_got_q;
	logic                                w_got_q;
	logic [mqflag_pkg::AXI_ADDR_W-1:0]   awaddr_q;
	logic [31:0]                         wdata_q;
	mqflag_pkg::wr_state_t               wr_state_q;
	logic                                do_write;
	logic [mqflag_pkg::CTRL_W-1:0]       ctrl_q;
	logic [mqflag_pkg::WR_ADDR_W-1:0]    waddr_q;
	logic [mqflag_pkg::RD_ADDR_W-1:0]    raddr_q;
	logic                                wsel_q;
	logic                                rsel_q;
	logic                                strobe_q;
	logic                                oe_n_q;
	logic [1:0]                          bresp_q;
	logic                                wmapped;

	assign do_write = (wr_state_q == mqflag_pkg::WR_IDLE) && aw_got_q && w_got_q;
	assign wmapped  = awaddr_q == mqflag_pkg::CTRL_OFF || awaddr_q == mqflag_pkg::WSEL_OFF
		|| awaddr_q == mqflag_pkg::RSEL_OFF;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			aw_got_q   <= 1'b0;
			w_got_q    <= 1'b0;
			awaddr_q   <= '0;
			wdata_q    <= '0;
			wr_state_q <= mqflag_pkg::WR_IDLE;
			bresp_q    <= mqflag_pkg::RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
			end
			case (wr_state_q)
				mqflag_pkg::WR_IDLE:
					if (do_write)
					begin
						wr_state_q <= mqflag_pkg::WR_RESP;
						bresp_q    <= wmapped ? mqflag_pkg::RESP_OKAY : mqflag_pkg::RESP_SLVERR;
					end
				mqflag_pkg::WR_RESP:
					if (s_axi_bready)
					begin
						wr_state_q <= mqflag_pkg::WR_IDLE;
						aw_got_q   <= 1'b0;
						w_got_q    <= 1'b0;
					end
				default:
					wr_state_q <= mqflag_pkg::WR_IDLE;
			endcase
		end
	end

	assign s_axi_awready = !aw_got_q;
	assign s_axi_wready  = !w_got_q;
	assign s_axi_bvalid  = wr_state_q == mqflag_pkg::WR_RESP;
	assign s_axi_bresp   = bresp_q;

	//--------------------------------------------------------------------------
	// Link drive
	//--------------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl_q   <= mqflag_pkg::CTRL_RESET_VAL;
			waddr_q  <= '0;
			raddr_q  <= '0;
			wsel_q   <= 1'b0;
			rsel_q   <= 1'b0;
			strobe_q <= 1'b0;
			oe_n_q   <= 1'b1;
		end
		else
		begin
			wsel_q   <= 1'b0;
			rsel_q   <= 1'b0;
			strobe_q <= 1'b0;
			if (do_write && awaddr_q == mqflag_pkg::CTRL_OFF && s_axi_wstrb != 4'h0)
				ctrl_q <= wdata_q[mqflag_pkg::CTRL_W-1:0];
			if (do_write && awaddr_q == mqflag_pkg::WSEL_OFF)
			begin
				waddr_q  <= wdata_q[mqflag_pkg::WR_ADDR_W-1:0];
				wsel_q   <= 1'b1;
				strobe_q <= wdata_q[mqflag_pkg::SEL_FLAG_BIT]
					&& !link.serial_enable_out;
			end
			if (do_write && awaddr_q == mqflag_pkg::RSEL_OFF)
			begin
				raddr_q <= wdata_q[mqflag_pkg::RD_ADDR_W-1:0];
				rsel_q  <= 1'b1;
				oe_n_q  <= !wdata_q[mqflag_pkg::SEL_FLAG_BIT];
			end
		end
	end

	assign link.master_reset_n        = !ctrl_q[mqflag_pkg::CTRL_RESET_BIT];
	assign link.chip_select_code      = ctrl_q[mqflag_pkg::CTRL_CODE_LSB +: mqflag_pkg::CODE_W];
	assign link.primary_device_select = ctrl_q[mqflag_pkg::CTRL_PRIM_BIT];
	assign link.flag_mode_select      = ctrl_q[mqflag_pkg::CTRL_FMODE_BIT];
	assign link.input_width_sel       = ctrl_q[mqflag_pkg::CTRL_IW_BIT];
	assign link.output_width_sel      = ctrl_q[mqflag_pkg::CTRL_OW_BIT];
	assign link.bus_match_select      = ctrl_q[mqflag_pkg::CTRL_BM_BIT];
	assign link.write_queue_address   = waddr_q;
	assign link.write_queue_select    = wsel_q;
	assign link.read_queue_address    = raddr_q;
	assign link.read_queue_select     = rsel_q;
	assign link.almost_full_bus_strobe = strobe_q;
	assign link.output_enable_n       = oe_n_q;
	// Single-device wiring: loop in polled mode, low in direct mode
	assign link.almost_full_chain_in  = link.flag_mode_select
		&& link.almost_full_chain_out;

	//--------------------------------------------------------------------------
	// Read path and status capture
	//--------------------------------------------------------------------------
	logic [mqflag_pkg::NUM_QUEUES-1:0] flags_q;
	logic                              sync_seen_q;
	logic                              rvalid_q;
	logic [31:0]                       rdata_q;
	logic [1:0]                        rresp_q;
	logic [31:0]                       stat_word;
	logic                              rmapped;

	assign stat_word = {20'h00000, link.almost_full_chain_out, link.serial_enable_out,
		link.output_valid_line_n, sync_seen_q, flags_q};
	assign rmapped = s_axi_araddr == mqflag_pkg::CTRL_OFF || s_axi_araddr == mqflag_pkg::WSEL_OFF
		|| s_axi_araddr == mqflag_pkg::RSEL_OFF || s_axi_araddr == mqflag_pkg::STAT_OFF;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			flags_q     <= '1;
			sync_seen_q <= 1'b0;
			rvalid_q    <= 1'b0;
			rdata_q     <= '0;
			rresp_q     <= mqflag_pkg::RESP_OKAY;
		end
		else
		begin
			flags_q <= link.status_bus_line;
			if (link.almost_full_bus_sync)
				sync_seen_q <= 1'b1;
			else if (s_axi_arvalid && !rvalid_q && s_axi_araddr == mqflag_pkg::STAT_OFF)
				sync_seen_q <= 1'b0;
			if (s_axi_arvalid && !rvalid_q)
			begin
				rvalid_q <= 1'b1;
				rresp_q  <= rmapped ? mqflag_pkg::RESP_OKAY : mqflag_pkg::RESP_SLVERR;
				case (s_axi_araddr)
					mqflag_pkg::CTRL_OFF: rdata_q <= {23'h000000, ctrl_q};
					mqflag_pkg::WSEL_OFF: rdata_q <= {26'h0000000, waddr_q};
					mqflag_pkg::RSEL_OFF: rdata_q <= {23'h000000, !oe_n_q, 1'b0, raddr_q};
					mqflag_pkg::STAT_OFF: rdata_q <= stat_word;
					default:              rdata_q <= '0;
				endcase
			end
			else if (rvalid_q && s_axi_rready)
				rvalid_q <= 1'b0;
		end
	end

	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

endmodule // mq_host_end

//--- mqflag_link_chk.sv
// Link checker for the controller and device ends
`timescale 1ns/1ps
module mqflag_link_chk (
	// Link signals
	input wire logic       core_clk,
	input wire logic       resetn,
	input wire logic       master_reset_n,
	input wire logic [2:0] chip_select_code,
	input wire logic       primary_device_select,
	input wire logic       flag_mode_select,
	input wire logic [5:0] write_queue_address,
	input wire logic [6:0] read_queue_address,
	input wire logic       read_queue_select,
	input wire logic       output_enable_n,
	input wire logic       almost_full_bus_strobe,
	input wire logic       almost_full_bus_sync,
	input wire logic       almost_full_chain_in,
	input wire logic       almost_full_chain_out,
	input wire logic       status_bus_oe_n,
	input wire logic       read_data_oe_n
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	AST_TOKEN: assert property (master_reset_n && almost_full_chain_in |=>
		!master_reset_n || almost_full_bus_sync) else $error("token lost");
	AST_SYNC_DRIVE: assert property (almost_full_bus_sync |-> !status_bus_oe_n)
		else $error("sync without bus");
	AST_CHAIN_SYNC: assert property (almost_full_chain_out |-> almost_full_bus_sync)
		else $error("chain out alone");
	AST_RING_START: assert property (!master_reset_n && primary_device_select &&
		flag_mode_select ##1 master_reset_n |-> ##[1:2] almost_full_bus_sync) else $error("no ring");
	AST_DIRECT_SEL: assert property (master_reset_n && !flag_mode_select &&
		almost_full_bus_strobe |-> ##2 status_bus_oe_n == ($past(write_queue_address[5:3], 2)
		!= $past(chip_select_code, 2))) else $error("direct select");
	AST_READ_SEL: assert property (master_reset_n && read_queue_select |=>
		read_data_oe_n == (output_enable_n || $past(read_queue_address[6:4])
		!= $past(chip_select_code))) else $error("read select");
	AST_OE_ASYNC: assert property (output_enable_n |-> read_data_oe_n)
		else $error("data driven");
	AST_SLAVE_START: assert property (!master_reset_n && !primary_device_select
		##1 master_reset_n |-> read_data_oe_n) else $error("secondary drives");
endmodule // mqflag_link_chk

//--- multiqueue_expansion_flag_bus_tb.sv
// Testbench joining controller and device ends over the link
`timescale 1ns/1ps
module multiqueue_expansion_flag_bus_tb;
	logic        core_clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, programming_done, write_queue_hit, read_queue_owned;
	logic        primary_mode, polled_mode;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp, input_width, output_width;
	logic [2:0]  write_queue_index, read_queue_index;
	logic [7:0]  queue_almost_full, queue_empty;
	logic [35:0] queue_read_word;
	int          err_total, tests_run;
	mq_link_if link ();
	mq_host_end i_mq_host_end (.core_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link);
	mq_device_end i_mq_device_end (.core_clk, .resetn, .link, .queue_almost_full, .queue_empty,
		.queue_read_word, .programming_done, .write_queue_hit, .write_queue_index,
		.read_queue_owned, .read_queue_index, .input_width, .output_width, .primary_mode,
		.polled_mode);
	mqflag_link_chk i_mqflag_link_chk (.core_clk, .resetn, .master_reset_n(link.master_reset_n),
		.chip_select_code(link.chip_select_code), .flag_mode_select(link.flag_mode_select),
		.primary_device_select(link.primary_device_select),
		.write_queue_address(link.write_queue_address), .output_enable_n(link.output_enable_n),
		.read_queue_address(link.read_queue_address), .read_queue_select(link.read_queue_select),
		.almost_full_bus_strobe(link.almost_full_bus_strobe), .read_data_oe_n(link.read_data_oe_n),
		.almost_full_bus_sync(link.almost_full_bus_sync), .status_bus_oe_n(link.status_bus_oe_n),
		.almost_full_chain_in(link.almost_full_chain_in),
		.almost_full_chain_out(link.almost_full_chain_out));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do
		begin
			@(posedge core_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, e}, {30'h0, s_axi_bresp});
		// Let the device take the select pulse
		@(posedge core_clk);
	endtask
	task automatic rd(input string n, input logic [3:0] a, input logic [31:0] m, e);
		// Status flags lag the link selects by three cycles
		repeat (3) @(posedge core_clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do
		begin
			@(posedge core_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(n, e, s_axi_rdata & m);
	endtask
	task automatic cfg(input logic [31:0] c, input logic [5:0] e);
		wr(4'h0, c | 32'h1, 2'h0);
		wr(4'h0, c, 2'h0);
		chk("config", {26'h0, e}, {26'h0, input_width, output_width, primary_mode, polled_mode});
	endtask
	task automatic wrap_up();
		$display("Compared %0d, mismatched %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	initial
	begin
		repeat (5000) @(posedge core_clk);
		err_total++;
		wrap_up();
	end
	initial
	begin
		{err_total, tests_run, resetn, programming_done, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_wstrb, queue_almost_full, queue_empty, queue_read_word} = {12'hf3c, 8'h08, 36'h987654321};
		repeat (20) @(posedge core_clk);
		resetn <= 1'b1;
		rd("ctrl", 4'h0, 32'h1ff, 32'h011);
		wr(4'hc, 32'h0, 2'h2);
		cfg(32'h1da, 6'h1a);
		wr(4'h4, 32'h108, 2'h0);
		rd("unprogrammed", 4'hc, 32'h5ff, 32'h4c3);
		programming_done <= 1'b1;
		wr(4'h4, 32'h12a, 2'h0);
		chk("wq_hit", 32'h1, {31'h0, write_queue_hit});
		rd("direct", 4'hc, 32'h5ff, 32'h0c3);
		wr(4'h4, 32'h108, 2'h0);
		rd("released", 4'hc, 32'h1ff, 32'h0ff);
		chk("wq_index", 32'h2, {29'h0, write_queue_index});
		$display("direct status test done");
		wr(4'h8, 32'h153, 2'h0);
		rd("ov_empty", 4'hc, 32'h200, 32'h200);
		chk("rd_sel", 32'hb, {28'h0, read_queue_owned, read_queue_index});
		chk("rdata", 32'h87654321, link.read_data_line[31:0]);
		queue_empty <= 8'h00;
		rd("ov_valid", 4'hc, 32'h200, 32'h000);
		wr(4'h8, 32'h113, 2'h0);
		chk("other_dev", 32'hffffffff, link.read_data_line[31:0]);
		cfg(32'h10a, 6'h20);
		chk("sec_idle", 32'hffffffff, link.read_data_line[31:0]);
		wr(4'h8, 32'h153, 2'h0);
		chk("sec_sel", 32'h87654321, link.read_data_line[31:0]);
		wr(4'h8, 32'h053, 2'h0);
		chk("sec_oe", 32'hffffffff, link.read_data_line[31:0]);
		$display("read port test done");
		cfg(32'h03a, 6'h2b);
		rd("polled", 4'hc, 32'h1ff, 32'h1c3);
		$display("polled ring test done");
		wrap_up();
	end
endmodule // multiqueue_expansion_flag_bus_tb
